// file: rtl/srm_regmap.sv
// register map of the pressure and temperature sensor behind its serial port
//
// Behaviour
// - pointer steps by one from 0x16 to 0x2C
// - pointer wraps from 0x2D to 0x0C
// - going to standby keeps all contents
// - entering active clears 0x00 to 0x05
// - target, window, min, max always writable
// - control locked in active except live bits
// - minimum pressure is twenty bits over three
// - maximum pressure is twenty bits over three
// - min and max temperature are byte pairs
// - targets and windows high byte first
// - fifo mode selects area a view
// - address 0x00 aliases ready or fifo flags
// - fifo off: 0x01 to 0x03 give pressure
// - fifo off: temperature, wrap 0x05 to 0x00
// - fifo on: 0x01 is draining read port
// - fifo on: 0x02 to 0x05 read zero
// - device answers at bus address 0x60
`timescale 1ns/1ps
`default_nettype none
module srm_regmap #(
  // identification byte, value is arbitrary
  parameter logic [7:0] ID_VALUE = 8'h3C
) (
  // clock, reset and freeze
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // measurement side
  input wire logic sample_load,
  input wire logic [19:0] pres_sample,
  input wire logic [11:0] temp_sample,
  input wire logic [7:0] ready_flags_in,
  // fifo side
  input wire logic [1:0] fifo_mode,
  input wire logic [7:0] fifo_flags,
  input wire logic [7:0] fifo_byte,
  output logic fifo_pop,
  // mode
  output logic active_mode,
  output logic act_entry,
  // stored settings
  output logic [15:0] pres_target,
  output logic [7:0] temp_target,
  output logic [15:0] pres_window,
  output logic [7:0] temp_window,
  output logic [19:0] pres_min,
  output logic [15:0] temp_min,
  output logic [19:0] pres_max,
  output logic [15:0] temp_max,
  output logic [7:0] control_one,
  output logic [7:0] control_two,
  output logic [7:0] control_three,
  output logic [7:0] control_four,
  output logic [7:0] control_five,
  output logic [7:0] pressure_user_trim,
  output logic [7:0] temp_user_trim,
  output logic [7:0] altitude_user_trim
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // index of a bank address into the array
  function automatic logic [4:0] bank_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - srm_pkg::A_PTGT_HI;
    return d[4:0];
  endfunction : bank_idx

  // inclusive address range test
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  // auto-increment successor of an address
  function automatic logic [7:0] next_addr(input logic [7:0] a,
                                           input logic [1:0] fm);
    logic [7:0] n;
    n = a + 8'h01;
    case (a)
      srm_pkg::A_PRES_HI:
        n = (fm != srm_pkg::FMODE_OFF) ? a : n;
      srm_pkg::A_TEMP_LO:
        n = srm_pkg::A_STATUS;
      srm_pkg::A_DELTA_END:
        n = srm_pkg::A_READY;
      srm_pkg::A_FIFO_OLD:
        n = a;
      srm_pkg::A_TRIM_H:
        n = srm_pkg::A_ID;
      default:
        n = a + 8'h01;
    endcase
    return n;
  endfunction : next_addr

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam int BANK_LAST = srm_pkg::BANK_SIZE - 1;
  logic [7:0] bank_q [0:BANK_LAST];
  logic [7:0] ptr_q;
  logic [19:0] pres_q;
  logic [11:0] temp_q;
  logic [7:0] ready_q;
  logic act_entry_q;
  logic [7:0] rd_data;
  logic wr_stb;
  logic wr_first;
  logic [7:0] wr_byte;
  logic rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // serial byte engine; drives low only, so the data line is tied zero
  srm_serial_slave u_link (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_first(wr_first),
    .wr_byte(wr_byte),
    .rd_take(rd_take),
    .rd_data(rd_data)
  );
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  wire [4:0] cur_idx = bank_idx(ptr_q);
  wire [4:0] c1_idx = bank_idx(srm_pkg::A_CTRL_ONE);
  wire [7:0] cur_byte = bank_q[cur_idx];
  wire wr_data = wr_stb & ~wr_first;
  wire step_c = rd_take | wr_data;
  // settings and trims may change in any mode
  wire in_free = in_rng(ptr_q, srm_pkg::A_PTGT_HI, srm_pkg::A_TMAX_LO) |
                 in_rng(ptr_q, srm_pkg::A_TRIM_P, srm_pkg::A_TRIM_H);
  wire in_ctrl = in_rng(ptr_q, srm_pkg::A_CTRL_ONE, srm_pkg::A_CTRL_FIVE);
  wire at_c1 = (ptr_q == srm_pkg::A_CTRL_ONE);
  // in active only the standby and reset bits of control_one move
  wire [7:0] live_mask = srm_pkg::CTRL_LIVE_MASK;
  wire [7:0] c1_merged = (cur_byte & ~live_mask) | (wr_byte & live_mask);
  wire [7:0] wr_value = (at_c1 & active_mode) ? c1_merged : wr_byte;
  // read-only addresses and locked controls never reach the array
  wire bank_we = wr_data & (in_free | (in_ctrl & ~active_mode) | at_c1);
  wire act_entry_c = wr_data & at_c1 & ~active_mode & wr_value[srm_pkg::STANDBY_ACTIVE_BIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // stored bank; leaving active touches nothing here
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < srm_pkg::BANK_SIZE; i++)
        bank_q[i] <= srm_pkg::REG_RESET;
    end
    else if (clk_en && bank_we)
      bank_q[cur_idx] <= wr_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register pointer; the first written byte of a frame loads it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= srm_pkg::A_STATUS;
    else if (clk_en)
    begin
      if (wr_stb && wr_first)
        ptr_q <= wr_byte;
      else if (step_c)
        ptr_q <= next_addr(ptr_q, fifo_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // real-time area; the clear on activation beats a sample landing with it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pres_q <= 20'h00000;
      temp_q <= 12'h000;
      ready_q <= srm_pkg::REG_RESET;
      act_entry_q <= 1'b0;
    end
    else if (clk_en)
    begin
      act_entry_q <= act_entry_c;
      if (act_entry_c)
      begin
        pres_q <= 20'h00000;
        temp_q <= 12'h000;
        ready_q <= srm_pkg::REG_RESET;
      end
      else if (sample_load)
      begin
        pres_q <= pres_sample;
        temp_q <= temp_sample;
        ready_q <= ready_flags_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; area a follows the fifo mode field
  wire fifo_on = (fifo_mode != srm_pkg::FMODE_OFF);
  always_comb
  begin
    rd_data = 8'h00;
    case (ptr_q)
      srm_pkg::A_STATUS:
        rd_data = fifo_on ? fifo_flags : ready_q;
      srm_pkg::A_PRES_HI:
        rd_data = fifo_on ? fifo_byte : pres_q[19:12];
      srm_pkg::A_PRES_MID:
        rd_data = fifo_on ? 8'h00 : pres_q[11:4];
      srm_pkg::A_PRES_LO:
        rd_data = fifo_on ? 8'h00 : {pres_q[3:0], 4'h0};
      srm_pkg::A_TEMP_HI:
        rd_data = fifo_on ? 8'h00 : temp_q[11:4];
      srm_pkg::A_TEMP_LO:
        rd_data = fifo_on ? 8'h00 : {temp_q[3:0], 4'h0};
      srm_pkg::A_READY:
        rd_data = ready_q;
      srm_pkg::A_ID:
        rd_data = ID_VALUE;
      srm_pkg::A_FIFO_FLAGS:
        rd_data = fifo_flags;
      default:
        rd_data = (in_free | in_ctrl) ? cur_byte : 8'h00;
    endcase
  end

  // each byte taken from the fifo port drains one entry
  assign fifo_pop = rd_take & fifo_on & (ptr_q == srm_pkg::A_PRES_HI);

  ////////////////////////////////////////////////////////////////////////////
  // field views of the bank
  assign active_mode = bank_q[c1_idx][srm_pkg::STANDBY_ACTIVE_BIT_BIT];
  assign act_entry = act_entry_q;
  // pairs are high byte first
  assign pres_target = {bank_q[bank_idx(srm_pkg::A_PTGT_HI)],
                        bank_q[bank_idx(srm_pkg::A_PTGT_LO)]};
  assign temp_target = bank_q[bank_idx(srm_pkg::A_TTGT)];
  assign pres_window = {bank_q[bank_idx(srm_pkg::A_PWND_HI)],
                        bank_q[bank_idx(srm_pkg::A_PWND_LO)]};
  assign temp_window = bank_q[bank_idx(srm_pkg::A_TWND)];
  // twenty-bit extremes take the low byte's upper nibble
  assign pres_min = {bank_q[bank_idx(srm_pkg::A_PMIN_HI)],
                     bank_q[bank_idx(srm_pkg::A_PMIN_MID)],
                     bank_q[bank_idx(srm_pkg::A_PMIN_LO)][7:4]};
  assign pres_max = {bank_q[bank_idx(srm_pkg::A_PMAX_HI)],
                     bank_q[bank_idx(srm_pkg::A_PMAX_MID)],
                     bank_q[bank_idx(srm_pkg::A_PMAX_LO)][7:4]};
  // temperature extremes
  assign temp_min = {bank_q[bank_idx(srm_pkg::A_TMIN_HI)],
                     bank_q[bank_idx(srm_pkg::A_TMIN_LO)]};
  assign temp_max = {bank_q[bank_idx(srm_pkg::A_TMAX_HI)],
                     bank_q[bank_idx(srm_pkg::A_TMAX_LO)]};
  assign control_one = bank_q[c1_idx];
  assign control_two = bank_q[bank_idx(srm_pkg::A_CTRL_TWO)];
  assign control_three = bank_q[bank_idx(srm_pkg::A_CTRL_THREE)];
  assign control_four = bank_q[bank_idx(srm_pkg::A_CTRL_FOUR)];
  assign control_five = bank_q[bank_idx(srm_pkg::A_CTRL_FIVE)];
  assign pressure_user_trim = bank_q[bank_idx(srm_pkg::A_TRIM_P)];
  assign temp_user_trim = bank_q[bank_idx(srm_pkg::A_TRIM_T)];
  assign altitude_user_trim = bank_q[bank_idx(srm_pkg::A_TRIM_H)];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_step_linear;
    clk_en && step_c && in_rng(ptr_q, srm_pkg::A_PTGT_HI, srm_pkg::A_TRIM_T)
      |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_step_linear: assert property (p_step_linear)
    else $error("pointer did not step by one in the bank");

  property p_wrap_id;
    clk_en && step_c && ptr_q == srm_pkg::A_TRIM_H |=> ptr_q == srm_pkg::A_ID;
  endproperty
  a_wrap_id: assert property (p_wrap_id)
    else $error("pointer did not wrap to the identification byte");

  property p_keep_standby;
    clk_en && wr_data && at_c1 && active_mode && !wr_byte[srm_pkg::STANDBY_ACTIVE_BIT_BIT]
      && !sample_load |=> $stable(pres_q) && $stable(temp_q) && !active_mode;
  endproperty
  a_keep_standby: assert property (p_keep_standby)
    else $error("contents changed on the move to standby");

  property p_clear_entry;
    clk_en && act_entry_c
      |=> pres_q == 20'h00000 && temp_q == 12'h000 && ready_q == 8'h00 && act_entry;
  endproperty
  a_clear_entry: assert property (p_clear_entry)
    else $error("area a not cleared on entry to active");

  property p_free_write;
    clk_en && wr_data && in_rng(ptr_q, srm_pkg::A_PTGT_HI, srm_pkg::A_TMAX_LO)
      |=> bank_q[$past(cur_idx)] == $past(wr_byte);
  endproperty
  a_free_write: assert property (p_free_write)
    else $error("setting write was lost");

  sequence s_locked_write;
    clk_en && wr_data && active_mode
      && in_rng(ptr_q, srm_pkg::A_CTRL_TWO, srm_pkg::A_CTRL_FIVE);
  endsequence
  property p_ctrl_lock;
    s_locked_write |=> bank_q[$past(cur_idx)] == $past(cur_byte);
  endproperty
  a_ctrl_lock: assert property (p_ctrl_lock)
    else $error("locked control register changed in active mode");

  property p_alias;
    ptr_q == srm_pkg::A_STATUS |-> rd_data == (fifo_on ? fifo_flags : ready_q);
  endproperty
  a_alias: assert property (p_alias)
    else $error("status alias shows the wrong register");

  property p_pres_view;
    !fifo_on && ptr_q == srm_pkg::A_PRES_MID |-> rd_data == pres_q[11:4];
  endproperty
  a_pres_view: assert property (p_pres_view)
    else $error("pressure middle byte wrong");

  property p_area_wrap;
    clk_en && step_c && ptr_q == srm_pkg::A_TEMP_LO |=> ptr_q == srm_pkg::A_STATUS;
  endproperty
  a_area_wrap: assert property (p_area_wrap)
    else $error("pointer did not wrap from 0x05");

  sequence s_fifo_take;
    clk_en && rd_take && fifo_on && ptr_q == srm_pkg::A_PRES_HI;
  endsequence
  property p_fifo_stay;
    s_fifo_take |=> ptr_q == srm_pkg::A_PRES_HI && $past(fifo_pop);
  endproperty
  a_fifo_stay: assert property (p_fifo_stay)
    else $error("fifo read port did not hold and pop");

  property p_reserved;
    fifo_on && in_rng(ptr_q, srm_pkg::A_PRES_MID, srm_pkg::A_TEMP_LO)
      |-> rd_data == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved area read not zero");

endmodule : srm_regmap
`default_nettype wire

// file: rtl/srm_pkg.sv
// shared constants of the sensor register map
package srm_pkg;
  // serial bus device address
  localparam logic [6:0] DEV_ADDR = 7'h60;
  // area a and status addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_PRES_HI = 8'h01;
  localparam logic [7:0] A_PRES_MID = 8'h02;
  localparam logic [7:0] A_PRES_LO = 8'h03;
  localparam logic [7:0] A_TEMP_HI = 8'h04;
  localparam logic [7:0] A_TEMP_LO = 8'h05;
  localparam logic [7:0] A_READY = 8'h06;
  localparam logic [7:0] A_DELTA_END = 8'h0B;
  localparam logic [7:0] A_ID = 8'h0C;
  localparam logic [7:0] A_FIFO_FLAGS = 8'h0D;
  localparam logic [7:0] A_FIFO_OLD = 8'h0E;
  // stored bank addresses
  localparam logic [7:0] A_PTGT_HI = 8'h16;
  localparam logic [7:0] A_PTGT_LO = 8'h17;
  localparam logic [7:0] A_TTGT = 8'h18;
  localparam logic [7:0] A_PWND_HI = 8'h19;
  localparam logic [7:0] A_PWND_LO = 8'h1A;
  localparam logic [7:0] A_TWND = 8'h1B;
  localparam logic [7:0] A_PMIN_HI = 8'h1C;
  localparam logic [7:0] A_PMIN_MID = 8'h1D;
  localparam logic [7:0] A_PMIN_LO = 8'h1E;
  localparam logic [7:0] A_TMIN_HI = 8'h1F;
  localparam logic [7:0] A_TMIN_LO = 8'h20;
  localparam logic [7:0] A_PMAX_HI = 8'h21;
  localparam logic [7:0] A_PMAX_MID = 8'h22;
  localparam logic [7:0] A_PMAX_LO = 8'h23;
  localparam logic [7:0] A_TMAX_HI = 8'h24;
  localparam logic [7:0] A_TMAX_LO = 8'h25;
  localparam logic [7:0] A_CTRL_ONE = 8'h26;
  localparam logic [7:0] A_CTRL_TWO = 8'h27;
  localparam logic [7:0] A_CTRL_THREE = 8'h28;
  localparam logic [7:0] A_CTRL_FOUR = 8'h29;
  localparam logic [7:0] A_CTRL_FIVE = 8'h2A;
  localparam logic [7:0] A_TRIM_P = 8'h2B;
  localparam logic [7:0] A_TRIM_T = 8'h2C;
  localparam logic [7:0] A_TRIM_H = 8'h2D;
  localparam int BANK_SIZE = 24;
  // field positions and masks of control_one
  localparam int STANDBY_ACTIVE_BIT_BIT = 0;
  localparam logic [7:0] CTRL_LIVE_MASK = 8'h05;
  // fifo mode encodings
  localparam logic [1:0] FMODE_OFF = 2'h0;
  localparam logic [1:0] FMODE_CIRC = 2'h1;
  localparam logic [1:0] FMODE_STOP = 2'h2;
  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage : srm_pkg

// file: rtl/srm_serial_slave.sv
// serial bus byte engine of the sensor register map
`timescale 1ns/1ps
`default_nettype none
module srm_serial_slave (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial pins, sda is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // byte side
  output logic wr_stb,
  output logic wr_first,
  output logic [7:0] wr_byte,
  output logic rd_take,
  input wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } srm_link_e;

  srm_link_e state_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic first_q;
  logic nack_q;

  ////////////////////////////////////////////////////////////////////////////
  // line events, pins are sampled as synchronous inputs
  wire start_c = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
  wire rise_c = scl_in & ~scl_q;
  wire fall_c = ~scl_in & scl_q;
  wire got8_c = (cnt_q == 4'h8);

  // pull low for acks and for zero data bits only
  assign sda_oe = (state_q == ST_AACK) | (state_q == ST_WACK) |
                  ((state_q == ST_RDATA) & ~tx_q[7]);

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer; start and stop win over any bit phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h00;
      tx_q <= 8'hFF;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      wr_stb <= 1'b0;
      wr_first <= 1'b0;
      wr_byte <= 8'h00;
      rd_take <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_stb <= 1'b0;
      rd_take <= 1'b0;
      if (start_c)
      begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
      end
      else if (stop_c)
        state_q <= ST_IDLE;
      else
        case (state_q)
          ST_ADDR, ST_WDATA:
            if (rise_c)
            begin
              sh_q <= {sh_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (fall_c && got8_c)
            begin
              if (state_q == ST_WDATA)
              begin
                wr_stb <= 1'b1;
                wr_byte <= sh_q;
                wr_first <= first_q;
                first_q <= 1'b0;
                state_q <= ST_WACK;
              end
              else if (sh_q[7:1] == srm_pkg::DEV_ADDR)
              begin
                rw_q <= sh_q[0];
                state_q <= ST_AACK;
              end
              else
                state_q <= ST_IDLE;
            end
          ST_AACK:
            if (fall_c)
            begin
              cnt_q <= 4'h0;
              first_q <= 1'b1;
              if (rw_q)
              begin
                tx_q <= rd_data;
                rd_take <= 1'b1;
                state_q <= ST_RDATA;
              end
              else
                state_q <= ST_WDATA;
            end
          ST_WACK:
            if (fall_c)
            begin
              cnt_q <= 4'h0;
              state_q <= ST_WDATA;
            end
          ST_RDATA:
            if (fall_c)
            begin
              if (cnt_q == 4'h7)
                state_q <= ST_RACK;
              else
              begin
                tx_q <= {tx_q[6:0], 1'b1};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          ST_RACK:
            if (rise_c)
              nack_q <= sda_in;
            else if (fall_c)
            begin
              if (!nack_q)
              begin
                tx_q <= rd_data;
                rd_take <= 1'b1;
                cnt_q <= 4'h0;
                state_q <= ST_RDATA;
              end
              else
                state_q <= ST_IDLE;
            end
          default:
            state_q <= ST_IDLE;
        endcase
    end
  end

endmodule : srm_serial_slave
`default_nettype wire

// file: testbench/srm_host_model.sv
// serial bus host model that reaches the register map through its pins
`timescale 1ns/1ps
`default_nettype none
module srm_host_model (
  // clock
  input wire logic sys_clk,
  // bus wires, sda is open drain with a pull-up
  input wire logic sda_line,
  output logic scl_out,
  output logic sda_drv
);
  ////////////////////////////////////////////////////////////////////////////////
  // both lines idle high; a released sda reads as the pull-up level
  initial scl_out = 1'b1;
  initial sda_drv = 1'b1;
  // every change lands on a falling edge, away from the sampling edge
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : gap
  // one bit; phases of four cycles keep well above the two-cycle minimum
  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    gap(4);
    scl_out = 1'b1;
    gap(2);
    r = sda_line;
    gap(2);
    scl_out = 1'b0;
  endtask : clk_bit
  // start, or repeated start before a read
  task automatic start();
    sda_drv = 1'b1;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_drv = 1'b0;
    gap(4);
    scl_out = 1'b0;
  endtask : start
  // stop leaves both lines released
  task automatic stop();
    sda_drv = 1'b0;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_drv = 1'b1;
    gap(4);
  endtask : stop
  // eight bits msb first, then the acknowledge bit; 8'hFF releases sda for reads
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                      output logic r9);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(nine, r9);
  endtask : xfer
endmodule : srm_host_model
`default_nettype wire

// file: testbench/srm_regmap_tb.sv
// self-checking bench of the sensor register map
`timescale 1ns/1ps
`default_nettype none
module srm_regmap_tb;
  localparam logic [7:0] ID = 8'h5A; // arbitrary identification value
  localparam logic [7:0] AREA [7] = '{8'h0E, 8'hAB, 8'hCD, 8'hE0, 8'h12, 8'h30, 8'h0E};
  logic sys_clk, rst_n, clk_en, sample_load, sda_oe, sda_out, fifo_pop, active_mode, act_entry;
  logic scl, sda_drv;
  logic [1:0] fifo_mode;
  logic [7:0] fifo_flags, fifo_byte, ready_flags_in, tt, tw, c1, c2, c3, c4, c5, tp, tr, th;
  logic [19:0] pres_sample, pres_min, pres_max;
  logic [11:0] temp_sample;
  logic [15:0] pres_target, pres_window, temp_min, temp_max;
  logic [7:0] wbuf [32];
  logic [7:0] rbuf [32];
  int n_mismatch = 0;
  int comparisons = 0;
  int pops = 0;
  int entries = 0;
  // wired-and of host and device on the pulled-up data line
  wire sda = sda_drv & ~sda_oe;
  ////////////////////////////////////////////////////////////////////////////////
  srm_regmap #(.ID_VALUE(ID)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample_load(sample_load),
    .pres_sample(pres_sample), .temp_sample(temp_sample), .ready_flags_in(ready_flags_in),
    .fifo_mode(fifo_mode), .fifo_flags(fifo_flags), .fifo_byte(fifo_byte),
    .fifo_pop(fifo_pop), .active_mode(active_mode), .act_entry(act_entry),
    .pres_target(pres_target), .temp_target(tt), .pres_window(pres_window),
    .temp_window(tw), .pres_min(pres_min), .temp_min(temp_min), .pres_max(pres_max),
    .temp_max(temp_max), .control_one(c1), .control_two(c2), .control_three(c3),
    .control_four(c4), .control_five(c5), .pressure_user_trim(tp),
    .temp_user_trim(tr), .altitude_user_trim(th)
  );
  srm_host_model u_host (.sys_clk(sys_clk), .sda_line(sda), .scl_out(scl), .sda_drv(sda_drv));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, fifo pop and activation pulse counters
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (fifo_pop === 1'b1) pops++;
  always @(posedge sys_clk) if (act_entry === 1'b1) entries++;
  // pattern written into the bank, unique per address
  function automatic logic [7:0] v(input logic [7:0] a);
    return a ^ 8'hA5;
  endfunction : v
  // wide enough for the longest packed group of bytes compared at once
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // address the device, then load the register pointer
  task automatic open(input logic [7:0] a);
    logic [7:0] rx;
    logic r9;
    u_host.start();
    u_host.xfer(8'hC0, 1'b1, rx, r9);
    check(r9, 1'b0);
    u_host.xfer(a, 1'b1, rx, r9);
  endtask : open
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] rx;
    logic r9;
    open(a);
    for (int i = 0; i < n; i++) u_host.xfer(wbuf[i], 1'b1, rx, r9);
    u_host.stop();
  endtask : wr
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    wbuf[0] = d;
    wr(a, 1);
  endtask : wr1
  // random read: repeated start, then n bytes with the last one refused
  task automatic rd(input logic [7:0] a, input int n);
    logic r9;
    open(a);
    u_host.start();
    u_host.xfer(8'hC1, 1'b1, rbuf[0], r9);
    for (int i = 0; i < n; i++) u_host.xfer(8'hFF, i == n - 1, rbuf[i], r9);
    u_host.stop();
  endtask : rd
  task automatic conclude();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // watchdog: the whole sequence needs about a quarter of this span
  initial
  begin
    #500000;
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [7:0] rx;
    logic r9;
    rst_n = 1'b0;
    clk_en = 1'b1;
    sample_load = 1'b0;
    fifo_mode = 2'h0;
    fifo_flags = 8'h44;
    fifo_byte = 8'h77;
    pres_sample = 20'hABCDE;
    temp_sample = 12'h123;
    ready_flags_in = 8'h0E;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    u_host.gap(2);
    // reset values over the whole bank, then the wrap to the identification byte
    rd(8'h16, 25);
    for (int i = 0; i < 24; i++) check(rbuf[i], 8'h00);
    check(rbuf[24], ID);
    $display("test reset values done");
    // burst write and read back of targets, windows, minima and maxima
    for (int i = 0; i < 16; i++) wbuf[i] = v(8'h16 + i[7:0]);
    wr(8'h16, 16);
    rd(8'h16, 16);
    for (int i = 0; i < 16; i++) check(rbuf[i], v(8'h16 + i[7:0]));
    // twenty-bit extremes keep only the upper nibble of their low byte
    check(pres_min, {v(8'h1C), v(8'h1D), v(8'h1E)} >> 4);
    check(pres_max, {v(8'h21), v(8'h22), v(8'h23)} >> 4);
    check({temp_min, temp_max}, {v(8'h1F), v(8'h20), v(8'h24), v(8'h25)});
    check({pres_target, tt, pres_window, tw}, {v(8'h16), v(8'h17), v(8'h18),
                                                v(8'h19), v(8'h1A), v(8'h1B)});
    // controls two to five and two trims, written in standby
    for (int i = 0; i < 6; i++) wbuf[i] = v(8'h27 + i[7:0]);
    wr(8'h27, 6);
    check({c2, c3, c4, c5, tp, tr}, {v(8'h27), v(8'h28), v(8'h29),
                                     v(8'h2A), v(8'h2B), v(8'h2C)});
    // a burst past 0x2D lands on the read-only identification byte
    wbuf[1] = 8'h99;
    wbuf[0] = 8'h31;
    wr(8'h2D, 2);
    check(th, 8'h31);
    rd(8'h0C, 1);
    check(rbuf[0], ID);
    $display("test bank burst done");
    // control lock in active mode, live bits and always-writable settings
    wr1(8'h27, 8'h11);
    wr1(8'h26, 8'h01);
    check(active_mode, 1'b1);
    wr1(8'h27, 8'h22);
    check(c2, 8'h11);
    wr1(8'h26, 8'h07);
    check(c1, 8'h05);
    wr1(8'h16, 8'h5E);
    check(pres_target[15:8], 8'h5E);
    wr1(8'h26, 8'h00);
    check({active_mode, c1}, 9'h000);
    check({pres_target[7:0], pres_min},
          {v(8'h17), v(8'h1C), v(8'h1D), v(8'h1E)} >> 4);
    $display("test control lock done");
    // area a with the fifo off, then in both fifo modes
    // a second load while frozen must be lost
    sample_load = 1'b1;
    u_host.gap(1);
    clk_en = 1'b0;
    pres_sample = 20'h12345;
    u_host.gap(1);
    clk_en = 1'b1;
    sample_load = 1'b0;
    rd(8'h00, 7);
    for (int i = 0; i < 7; i++) check(rbuf[i], AREA[i]);
    for (int m = 1; m < 3; m++)
    begin
      fifo_mode = m[1:0];
      pops = 0;
      rd(8'h00, 3);
      check({rbuf[0], rbuf[1], rbuf[2], pops[7:0]}, 32'h44777702);
      rd(8'h02, 5);
      check({rbuf[0], rbuf[1], rbuf[2], rbuf[3], rbuf[4]}, 40'h0000000044);
    end
    $display("test area a done");
    // entering active clears area a but keeps the bank
    fifo_mode = 2'h0;
    wr1(8'h26, 8'h01);
    rd(8'h00, 6);
    for (int i = 0; i < 6; i++) check(rbuf[i], 8'h00);
    check(pres_target[15:8], 8'h5E);
    check(entries, 2);
    wr1(8'h26, 8'h00);
    // a foreign bus address gets no acknowledge
    u_host.start();
    u_host.xfer(8'hC2, 1'b1, rx, r9);
    check(r9, 1'b1);
    check(sda_out, 1'b0);
    u_host.stop();
    $display("test active entry and address done");
    conclude();
  end
endmodule : srm_regmap_tb
`default_nettype wire
